/* core/apdu_top.sv */
/*
 * apdu_top: automatic power-down unit with chip-select gating, fast-mode
 * and signal-blocking controls.
 * Assumes all inputs synchronous to core_clk; the logic clock input is
 * sampled as a level and its rising edges clock the idle counter.
 */
// Function
// - enabled and strobe idle, a four-bit idle counter runs on logic clock
// - fifteen idle logic clock periods raise power-down flag and enter power-down
// - enabling the unit also enables power-down entry, no extra step
// - strobe pulsing again returns the device to normal mode
// - chip select low or reset low also leaves power-down
// - in power-down the bus is blocked from memories and logic arrays
// - entering power-down deselects all memories internally
// - blocking logic clock from arrays never stops the idle counter
// - memories and io block standby in power-down, port drivers off, logic stays active
// - power-down keeps io levels, address outputs undefined, data tri-stated
// - power-down leaves logic behaviour to fast-mode, clock block and blocking bits only
// - fast-mode bit resets to fast on, setting it turns fast off
// - each set blocking bit stops its signal reaching both arrays
// - chip select active low, high disables flashes, static memory, io block
// - chip select high only idles memories and io block, blocks nothing
// - logic clock pin clocks both macrocells and idle counter
// - strobe on first port d pin is the monitored activity source
// - counter idle when disabled or pulsing, counts at the polarity level
// - fast-mode control lives at bit 3 of power control register a
`timescale 1ns/1ps
`default_nettype none
module apdu_top
    import apdu_pkg::*;
#(
    parameter int NUM_BLK = apdu_pkg::APDU_NUM_BLK
)(
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          strobe_pin,
    input  wire logic                          logic_clock_pin,
    input  wire logic                          select_pin,
    input  wire logic                          auto_sleep_en,
    input  wire logic                          strobe_idle_pol,
    input  wire logic                          reg_wr_a,
    input  wire logic                          reg_wr_c,
    input  wire logic [apdu_pkg::APDU_REG_W-1:0] reg_wdata,
    input  wire logic [NUM_BLK-1:0]            pld_sig_in,
    input  wire logic                          addr_out_en_in,
    input  wire logic                          data_out_en_in,
    output logic                               power_down_flag,
    output logic                               mem_select,
    output logic                               io_block_select,
    output logic                               bus_pass_en,
    output logic                               pld_fast_mode,
    output logic                               pld_clock_en,
    output logic [NUM_BLK-1:0]                 pld_sig_out,
    output logic                               addr_out_en,
    output logic                               data_out_en,
    output logic [apdu_pkg::APDU_REG_W-1:0]    power_ctrl_reg_a,
    output logic [apdu_pkg::APDU_REG_W-1:0]    power_ctrl_reg_c
);
    import apdu_pkg::*;

    apdu_state_t            state;
    logic [APDU_CNT_W-1:0]  idle_cnt;
    logic                   strobe_q;
    logic                   lclk_q;
    logic                   strobe_armed;
    logic                   strobe_edge;
    logic                   lclk_rise;
    logic                   strobe_idle;
    logic                   wake;
    logic                   next_down;
    logic                   next_sel;
    logic                   next_cs_sel;

    // edge detection on synchronous pin samples
    // the arm bit masks the first compare, so reset cannot fake a strobe edge
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_q <= 1'b0;
            lclk_q   <= 1'b0;
            strobe_armed <= 1'b0;
        end
        else
        begin
            strobe_q <= strobe_pin;
            lclk_q   <= logic_clock_pin;
            strobe_armed <= 1'b1;            // history is valid from here on
        end
    end

    assign strobe_edge = strobe_armed && (strobe_pin != strobe_q);
    assign lclk_rise   = logic_clock_pin & ~lclk_q;
    assign strobe_idle = !strobe_edge && (strobe_pin == strobe_idle_pol);
    // chip select low or strobe activity ends power-down; reset is async
    assign wake        = strobe_edge || !select_pin;
    assign next_down   = (state == APDU_RUN) && auto_sleep_en && strobe_idle && lclk_rise
                         && (idle_cnt == APDU_IDLE_LIMIT - 4'h1);
    assign next_cs_sel = !select_pin;

    // idle counter ticks only on logic clock edges, never gated by the block bits
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            idle_cnt <= APDU_CNT_RST;
        else if (!auto_sleep_en || !strobe_idle || wake)
            idle_cnt <= APDU_CNT_RST;
        else if (lclk_rise && idle_cnt != APDU_IDLE_LIMIT)
            idle_cnt <= idle_cnt + 4'h1;
    end

    // power-down state
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= APDU_RUN;
        else
        begin
            unique case (state)
                APDU_RUN:
                    if (next_down)
                        state <= APDU_DOWN;
                APDU_DOWN:
                    if (wake || !auto_sleep_en)
                        state <= APDU_RUN;
            endcase
        end
    end

    assign next_sel = next_cs_sel && !next_down && (state == APDU_RUN || wake);

    // registered outputs reflecting mode; memories deselected while down
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_down_flag <= 1'b0;
            mem_select      <= 1'b0;
            io_block_select <= 1'b0;
            bus_pass_en     <= 1'b1;
        end
        else
        begin
            power_down_flag <= next_down || (state == APDU_DOWN && !wake && auto_sleep_en);
            mem_select      <= next_sel;
            io_block_select <= next_sel;
            bus_pass_en     <= !(next_down ||
                                 (state == APDU_DOWN && !wake && auto_sleep_en));
        end
    end

    // power control registers written by the microcontroller at run time
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_ctrl_reg_a <= APDU_REG_A_RST;
            power_ctrl_reg_c <= APDU_REG_C_RST;
        end
        else
        begin
            if (reg_wr_a)
                power_ctrl_reg_a <= reg_wdata;
            if (reg_wr_c)
                power_ctrl_reg_c <= reg_wdata;
        end
    end

    // logic array controls; power-down does not touch them
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pld_fast_mode <= 1'b1;
            pld_clock_en  <= 1'b1;
        end
        else
        begin
            pld_fast_mode <= !power_ctrl_reg_a[APDU_FAST_BIT];
            pld_clock_en  <= !power_ctrl_reg_a[APDU_CLK_BLK_BIT];
        end
    end

    // per-signal blocking into both arrays; chip select and power-down leave them alone
    for (genvar i = 0; i < NUM_BLK; i++)
    begin : g_blk
        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
                pld_sig_out[i] <= 1'b0;
            else
                pld_sig_out[i] <= pld_sig_in[i] && !power_ctrl_reg_c[i];
        end
    end

    // port drivers: address outputs stop, data tri-state in power-down
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_out_en <= 1'b0;
            data_out_en <= 1'b0;
        end
        else
        begin
            addr_out_en <= addr_out_en_in && bus_pass_en;
            data_out_en <= data_out_en_in && bus_pass_en;
        end
    end

    property p_down_after_idle;
        @(posedge core_clk) disable iff (!rst_n)
        (next_down) |=> power_down_flag && !bus_pass_en && !mem_select;
    endproperty
    a_down_after_idle: assert property (p_down_after_idle) else $error("no power-down");

    property p_wake;
        @(posedge core_clk) disable iff (!rst_n)
        (state == APDU_DOWN && strobe_edge) |=> !power_down_flag ##1 state == APDU_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on strobe");

    property p_cnt_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (!auto_sleep_en) |=> idle_cnt == APDU_CNT_RST;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter ran disabled");

    property p_fast;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr_a) |=> ##1 pld_fast_mode == !$past(reg_wdata[APDU_FAST_BIT], 2);
    endproperty
    a_fast: assert property (p_fast) else $error("fast-mode bit wrong");

    property p_cs;
        @(posedge core_clk) disable iff (!rst_n)
        (select_pin) |=> !mem_select && !io_block_select;
    endproperty
    a_cs: assert property (p_cs) else $error("select high kept memory");

    property p_data_tri;
        @(posedge core_clk) disable iff (!rst_n)
        (!bus_pass_en) |=> !data_out_en;
    endproperty
    a_data_tri: assert property (p_data_tri) else $error("data driven when down");

    property p_block;
        @(posedge core_clk) disable iff (!rst_n)
        (power_ctrl_reg_c[0]) |=> !pld_sig_out[0];
    endproperty
    a_block: assert property (p_block) else $error("blocked signal passed");

    property p_cnt_step;
        @(posedge core_clk) disable iff (!rst_n)
        (auto_sleep_en && strobe_idle && !wake && lclk_rise
            && idle_cnt < APDU_IDLE_LIMIT - 4'h1)
            |=> idle_cnt == $past(idle_cnt) + 4'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter stalled");

    // counter moves only on logic clock rises, whatever the array clock gate says
    property p_cnt_blk;
        @(posedge core_clk) disable iff (!rst_n)
        (!pld_clock_en && auto_sleep_en && strobe_idle && !wake && lclk_rise
            && idle_cnt < APDU_IDLE_LIMIT - 4'h1)
            |=> idle_cnt == $past(idle_cnt) + 4'h1;
    endproperty
    a_cnt_blk: assert property (p_cnt_blk) else $error("blocked clock stopped counter");

    property p_cnt_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (auto_sleep_en && strobe_idle && !wake && !lclk_rise) |=> $stable(idle_cnt);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without clock");

    // wake is two steps: a down state meets a wake cause, then the device runs again
    sequence s_down_woken;
        state == APDU_DOWN && wake;
    endsequence

    sequence s_running;
        !power_down_flag && bus_pass_en;
    endsequence

    property p_wake_any;
        @(posedge core_clk) disable iff (!rst_n)
        s_down_woken |=> s_running;
    endproperty
    a_wake_any: assert property (p_wake_any) else $error("wake cause ignored");

    property p_sel_wake;
        @(posedge core_clk) disable iff (!rst_n)
        (state == APDU_DOWN && !select_pin) |=> !power_down_flag && mem_select && io_block_select;
    endproperty
    a_sel_wake: assert property (p_sel_wake) else $error("select low did not wake");

    property p_down_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (state == APDU_DOWN && !wake && auto_sleep_en) |=> power_down_flag && !bus_pass_en;
    endproperty
    a_down_hold: assert property (p_down_hold) else $error("bus open while down");

    property p_clk_blk;
        @(posedge core_clk) disable iff (!rst_n)
        (reg_wr_a) |=> ##1 pld_clock_en == !$past(reg_wdata[APDU_CLK_BLK_BIT], 2);
    endproperty
    a_clk_blk: assert property (p_clk_blk) else $error("clock block bit wrong");

    // unblocked signals pass whatever the mode or the chip select
    property p_sig_pass;
        @(posedge core_clk) disable iff (!rst_n)
        (!power_ctrl_reg_c[0]) |=> pld_sig_out[0] == $past(pld_sig_in[0]);
    endproperty
    a_sig_pass: assert property (p_sig_pass) else $error("unblocked signal lost");
endmodule // apdu_top
`default_nettype wire

/* core/apdu_pkg.sv */
/*
 * apdu_pkg: constants for the automatic power-down unit.
 * Assumes a single core clock domain; no register bus.
 */
package apdu_pkg;
    localparam int          APDU_CNT_W        = 4;           // idle counter width
    localparam logic [3:0]  APDU_IDLE_LIMIT   = 4'hf;        // fifteen idle logic clocks
    localparam logic [3:0]  APDU_CNT_RST      = 4'h0;
    localparam int          APDU_FAST_BIT     = 3;           // fast-mode bit in reg a
    localparam int          APDU_REG_W        = 8;
    localparam logic [7:0]  APDU_REG_A_RST    = 8'h00;       // fast mode on by default
    localparam logic [7:0]  APDU_REG_C_RST    = 8'h00;       // nothing blocked
    localparam int          APDU_NUM_BLK      = 8;           // blockable pld signals
    localparam int          APDU_CLK_BLK_BIT  = 4;           // logic clock block, reg a
    typedef enum logic [0:0] {APDU_RUN, APDU_DOWN} apdu_state_t;
endpackage

/* tb/apdu_mcu_model.sv */
/*
 * apdu_mcu_model: bus-side model that drives the address strobe and the logic clock.
 * Assumes the bench calls its tasks 2 ns after a rising core_clk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module apdu_mcu_model
(
    input  wire logic core_clk,
    input  wire logic idle_level,
    output var  logic strobe_pin,
    output var  logic logic_clock_pin
);
    // strobe rests at its idle level, logic clock stands low outside bursts
    initial
    begin
        strobe_pin = 1'b1;
        logic_clock_pin = 1'b0;
    end
    // all changes land 2 ns after an edge so sampling never races
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    // four core clocks a period, so every rise is seen by the sampler
    task automatic tick(input int n);
        repeat (n)
        begin
            logic_clock_pin = 1'b1;
            hold(2);
            logic_clock_pin = 1'b0;
            hold(2);
        end
    endtask
    // one bus cycle: strobe leaves its idle level briefly
    task automatic pulse();
        strobe_pin = ~idle_level;
        hold(2);
        strobe_pin = idle_level;
        hold(1);
    endtask
    task automatic rest();
        strobe_pin = idle_level;
        hold(1);
    endtask
endmodule // apdu_mcu_model
`default_nettype wire

/* tb/tb.sv */
/*
 * tb: self-checking bench for apdu_top, with the bus-side model.
 * Assumes core/apdu_pkg.sv and core/apdu_top.sv are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import apdu_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       select_pin = 1'b1;
    logic       en = 1'b1;
    logic       pol = 1'b1;
    logic       wr_a = 1'b0;
    logic       wr_c = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] sig_in = 8'hff;
    logic       aoe_in = 1'b1;
    logic       doe_in = 1'b1;
    logic       strobe_pin, lck, flag, msel, iosel, pass, fast, cken, doe, aoe;
    logic [7:0] sig_out, reg_a, reg_c;
    int         n_errors = 0;
    int         total_checks = 0;
    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;
    apdu_mcu_model mcu (.core_clk(core_clk), .idle_level(pol), .strobe_pin(strobe_pin),
        .logic_clock_pin(lck));
    apdu_top uut (
        .core_clk(core_clk), .rst_n(rst_n), .strobe_pin(strobe_pin),
        .logic_clock_pin(lck), .select_pin(select_pin), .auto_sleep_en(en),
        .strobe_idle_pol(pol), .reg_wr_a(wr_a), .reg_wr_c(wr_c), .reg_wdata(wdata),
        .pld_sig_in(sig_in), .addr_out_en_in(aoe_in), .data_out_en_in(doe_in),
        .power_down_flag(flag), .mem_select(msel), .io_block_select(iosel),
        .bus_pass_en(pass), .pld_fast_mode(fast), .pld_clock_en(cken),
        .pld_sig_out(sig_out), .addr_out_en(aoe), .data_out_en(doe),
        .power_ctrl_reg_a(reg_a), .power_ctrl_reg_c(reg_c));
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait, the flag settles a cycle or two after its cause
    task automatic wait_flag(input logic exp);
        int i;
        i = 0;
        while (flag !== exp && i < 12)
        begin
            step(1);
            i++;
        end
        chk(flag, exp);
    endtask
    // one-cycle write pulse to register a or c
    task automatic wr(input logic to_a, input logic [7:0] v);
        wdata = v;
        wr_a = to_a;
        wr_c = ~to_a;
        step(1);
        wr_a = 1'b0;
        wr_c = 1'b0;
        step(1); // a back-to-back write never re-raises a strobe in the same step
    endtask
    task automatic t_regs();
        chk(reg_a, APDU_REG_A_RST);
        chk(reg_c, APDU_REG_C_RST);
        chk(fast, 1'b1);
        wr(1'b1, 8'h08);
        step(3);
        chk(fast, 1'b0);
        chk(reg_a, 8'h08);
        aoe_in = 1'b0;
        doe_in = 1'b0;
        step(2);
        chk(aoe, 1'b0);
        chk(doe, 1'b0);
        aoe_in = 1'b1;
        doe_in = 1'b1;
        step(2);
        chk(aoe, 1'b1);
        chk(doe, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            wr(1'b0, 8'h01 << i);
            step(2);
            chk(sig_out, 8'hff ^ (8'h01 << i));
        end
        wr(1'b0, 8'h00);
        wr(1'b1, 8'h10);
        step(3);
        chk(fast, 1'b1);
        chk(cken, 1'b0);
        mcu.tick(15);
        wait_flag(1'b1);
        mcu.pulse();
        wait_flag(1'b0);
        wr(1'b1, 8'h00);
        step(2);
    endtask
    // enable alone is enough: 14 idle rises stay awake, the 15th sleeps
    task automatic t_sleep();
        mcu.tick(14);
        step(2);
        chk(flag, 1'b0);
        chk(pass, 1'b1);
        mcu.tick(1);
        wait_flag(1'b1);
        step(1);
        chk(pass, 1'b0);
        chk(msel, 1'b0);
        chk(iosel, 1'b0);
        chk(doe, 1'b0);
        chk(fast, 1'b1);
        sig_in = 8'h3c;
        step(2);
        chk(sig_out, 8'h3c);
        chk(flag, 1'b1);
    endtask
    task automatic t_wake_strobe();
        mcu.pulse();
        wait_flag(1'b0);
        step(1);
        chk(pass, 1'b1);
        mcu.tick(14);
        step(2);
        chk(flag, 1'b0);
        mcu.tick(1);
        wait_flag(1'b1);
    endtask
    task automatic t_wake_sel();
        select_pin = 1'b0;
        wait_flag(1'b0);
        step(1);
        chk(msel, 1'b1);
        chk(iosel, 1'b1);
        select_pin = 1'b1;
        sig_in = 8'h5a;
        step(2);
        chk(msel, 1'b0);
        chk(sig_out, 8'h5a);
    endtask
    task automatic t_wake_rst();
        mcu.tick(15);
        wait_flag(1'b1);
        rst_n = 1'b0;
        #1;
        chk(flag, 1'b0);
        chk(pass, 1'b1);
        step(1);
        rst_n = 1'b1;
        step(1);
    endtask
    task automatic t_pol();
        en = 1'b0;
        mcu.tick(20);
        step(2);
        chk(flag, 1'b0);
        en = 1'b1;
        pol = 1'b0;
        mcu.rest();
        mcu.tick(15);
        wait_flag(1'b1);
        mcu.pulse();
        wait_flag(1'b0);
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog, the whole sequence needs well under a tenth of this
    initial
    begin
        #200000;
        n_errors++;
        complete_run();
    end
    initial
    begin
        step(10);
        rst_n = 1'b1;
        step(2);
        t_regs();
        t_sleep();
        t_wake_strobe();
        t_wake_sel();
        t_wake_rst();
        t_pol();
        complete_run();
    end
endmodule // tb
`default_nettype wire
